/* cwg_core.sv */
// How it works
// RQ1: Four-bit selector picks data input from fifteen sources; code 1111 gives none.
// RQ2: Each output has its own polarity bit: set active-high, clear active-low.
// RQ3: Polarity never touches override levels, shutdown or steering behaviour.
// RQ4: Dead band is inserted only in half-bridge and full-bridge modes.
// RQ5: Two 6-bit counters: rising/reverse and falling/forward dead bands.
// RQ6: Dead band counts generator clock periods from zero up to setting.
// RQ7: Full-bridge direction change flips A and C at once, modulated output delayed.
// RQ8: Rising interval delays A in half-bridge, only B on forward-to-reverse.
// RQ9: Falling interval delays B in half-bridge, only D on reverse-to-forward.
// RQ10: Each interval programmable in generator clock periods from the count setting.
// RQ11: Dead band starts on input edge; count zero means no dead band.
// RQ12: Input changing back before count ends gives no output pulse.
// RQ13: Counts double-buffered: direct load when disabled, else after load request sequence.
// RQ14: Delay varies at most one generator period beyond programmed count.
// RQ15: Software shutdown set forces shutdown; without auto-restart software must clear it.
// RQ16: With auto-restart hardware clears shutdown and resumes at next rising edge.
// RQ17: Any enabled active shutdown input forces override levels without software; in steering modes an output with steering disabled keeps i_steer_level.
// RQ18: Seven sources enabled separately; pin, comparators, logic cell low, timers high.
// RQ19: Shutdown is level sensitive; cannot clear while enabled source stays active.
// RQ20: One 2-bit field sets B/D override levels, another sets A/C.
// RQ21: Interrupt flag set whenever shutdown bit gets set by hardware or software.
// RQ22: Restart only after shutdown source has gone or its enable is cleared.
// RQ23: After shutdown clears, output generation resumes at first rising data edge.
// RQ24: Mode field decodes steering, full-bridge, half-bridge, push-pull; 110, 111 reserved.
// RQ25: Data and shutdown inputs are synchronised before use; shutdown path is short.
`timescale 1ns/10ps

// Dead-band interval timer, one per edge direction
module cwg_db_timer (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_start,
  input  wire logic       i_stop,
  input  wire logic       i_tick,
  input  wire logic [5:0] i_limit,
  output logic            o_done
);
  logic       run_reg, run_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [6:0] cnt_inc;
  // Count ticks from zero; done on the tick that reaches the limit
  always_comb begin
    cnt_inc  = {1'b0, cnt_reg} + 7'h01;
    o_done   = run_reg & i_tick & ~i_stop & (cnt_inc == {1'b0, i_limit}); // see RQ6, see RQ14
    run_next = run_reg;
    cnt_next = cnt_reg;
    if (i_stop) begin
      run_next = 1'b0; // see RQ12
    end else if (i_start) begin
      run_next = 1'b1;
      cnt_next = 6'h00;
    end else if (o_done) begin
      run_next = 1'b0;
    end else if (run_reg & i_tick) begin
      cnt_next = cnt_inc[5:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_reg <= 1'b0;
      cnt_reg <= 6'h00;
    end else begin
      run_reg <= run_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule : cwg_db_timer

`include "cwg_cfg.svh"

module cwg_core (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_n,
  input  wire logic       i_enable,
  input  wire logic [2:0] i_mode,
  input  wire logic [3:0] i_input_source_select,
  input  wire logic       i_input_pin_route,
  input  wire logic [3:0] i_src_ccp,
  input  wire logic [1:0] i_src_pwm,
  input  wire logic       i_src_nco,
  input  wire logic [1:0] i_src_cmp,
  input  wire logic       i_src_dsm,
  input  wire logic [3:0] i_src_clc,
  input  wire logic [3:0] i_output_polarity,
  input  wire logic [3:0] i_steer_enable,
  input  wire logic [3:0] i_steer_level,
  input  wire logic [1:0] i_override_level_bd,
  input  wire logic [1:0] i_override_level_ac,
  input  wire logic [6:0] i_shutdown_source_enable,
  input  wire logic       i_sd_pin_n,
  input  wire logic [2:0] i_sd_tmr,
  input  wire logic [1:0] i_sd_cmp_n,
  input  wire logic       i_sd_clc_n,
  input  wire logic       i_auto_restart,
  input  wire logic       i_shutdown_set,
  input  wire logic       i_shutdown_clear,
  input  wire logic [5:0] i_rise_deadband_count,
  input  wire logic       i_rise_deadband_wr,
  input  wire logic [5:0] i_fall_deadband_count,
  input  wire logic       i_fall_deadband_wr,
  input  wire logic       i_deadband_load_request,
  output logic            o_out_a,
  output logic            o_out_b,
  output logic            o_out_c,
  output logic            o_out_d,
  output logic            o_shutdown,
  output logic            o_shutdown_irq_flag,
  output logic            o_deadband_load_pending
);
  cwg_pkg::mode_e      mode;
  cwg_pkg::run_state_e state_reg, state_next;
  logic [15:0]         src_vec;
  logic [7:0]          div_reg, div_next;
  logic [6:0]          sd_raw, sd_meta_reg, sd_sync_reg;
  logic [5:0]          rise_work_reg, rise_work_next, fall_work_reg, fall_work_next;
  logic [3:0]          str_reg, str_next, act, ovr, out_next;
  logic                src_sel, d_meta_reg, d_sync_reg, d_prev_reg, sd_any, rise, fall;
  logic                hb, fb, steer, running, tick, sd_reg, sd_next, irq_next;
  logic                ld_reg, ld_next, ld_armed_reg, ld_armed_next;
  logic                a_on_reg, a_on_next, b_on_reg, b_on_next;
  logic                dir_reg, dir_next, mod_ok_reg, mod_ok_next, pp_a_reg, pp_a_next;
  logic                dir_change, r_start, f_start, r_stop, f_stop, r_done, f_done;
  // Source mux ahead of the synchroniser; reserved code reads as a constant low
  assign src_vec = {1'b0, i_src_clc, i_src_dsm, i_src_cmp, i_src_nco, i_src_pwm, i_src_ccp, i_input_pin_route};
  assign src_sel = src_vec[i_input_source_select]; // see RQ1
  // Active-high view of each shutdown source; enables apply after the synchroniser
  assign sd_raw = {~i_sd_clc_n, ~i_sd_cmp_n, i_sd_tmr, ~i_sd_pin_n}; // see RQ18
  // Two-flop synchronisers for the data input and shutdown sources
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      d_meta_reg  <= 1'b0;
      d_sync_reg  <= 1'b0;
      d_prev_reg  <= 1'b0;
      sd_meta_reg <= 7'h00;
      sd_sync_reg <= 7'h00;
    end else begin
      d_meta_reg  <= src_sel; // see RQ25
      d_sync_reg  <= d_meta_reg;
      d_prev_reg  <= d_sync_reg;
      sd_meta_reg <= sd_raw;
      sd_sync_reg <= sd_meta_reg;
    end
  end

  // Decode and edge detection on the synchronised data
  always_comb begin
    mode    = cwg_pkg::mode_e'(i_mode); // see RQ24
    hb      = (mode == cwg_pkg::MODE_HALF);
    fb      = (mode == cwg_pkg::MODE_FB_FWD) | (mode == cwg_pkg::MODE_FB_REV);
    steer   = (mode == cwg_pkg::MODE_STEER_ASYNC) | (mode == cwg_pkg::MODE_STEER_SYNC);
    rise    = d_sync_reg & ~d_prev_reg;
    fall    = ~d_sync_reg & d_prev_reg;
    sd_any  = |(sd_sync_reg & i_shutdown_source_enable); // see RQ19
    // The rising edge that ends a resume already drives the waveform, so no cycle is lost
    running = (state_reg == cwg_pkg::ST_RUN) | ((state_reg == cwg_pkg::ST_RESUME) & rise & ~sd_reg); // see RQ23
    tick    = (div_reg == `CWG_GEN_DIV_LAST);
    div_next = tick ? 8'h00 : div_reg + 8'h01;
  end
  // Shutdown bit: set wins over any clear; no clear while a source is active
  always_comb begin
    sd_next = sd_reg;
    if ((i_shutdown_clear | i_auto_restart) & ~sd_any) sd_next = 1'b0; // see RQ15, see RQ16, see RQ22
    if (sd_any | i_shutdown_set) sd_next = 1'b1; // see RQ15, see RQ17
    irq_next = sd_next & ~sd_reg; // see RQ21
  end
  // Run control: after shutdown or enable, wait for a rising data edge
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cwg_pkg::ST_IDLE:   if (i_enable) state_next = cwg_pkg::ST_RESUME;
      cwg_pkg::ST_RUN:    if (sd_reg) state_next = cwg_pkg::ST_SHUT;
      cwg_pkg::ST_SHUT:   if (!sd_reg) state_next = cwg_pkg::ST_RESUME;
      cwg_pkg::ST_RESUME: begin
        if (sd_reg) state_next = cwg_pkg::ST_SHUT;
        else if (rise) state_next = cwg_pkg::ST_RUN; // see RQ16, see RQ23
      end
      default: state_next = cwg_pkg::ST_IDLE;
    endcase
    if (!i_enable) state_next = cwg_pkg::ST_IDLE;
  end
  // Dead-band working copies and the load-request sequence
  always_comb begin
    rise_work_next = rise_work_reg;
    fall_work_next = fall_work_reg;
    ld_next        = ld_reg;
    ld_armed_next  = ld_armed_reg;
    if (!i_enable) begin
      ld_next       = 1'b0;
      ld_armed_next = 1'b0;
      if (i_rise_deadband_wr) rise_work_next = i_rise_deadband_count; // see RQ13
      if (i_fall_deadband_wr) fall_work_next = i_fall_deadband_count;
    end else begin
      if (ld_reg & fall) ld_armed_next = 1'b1;
      if (ld_armed_reg & rise) begin
        rise_work_next = i_rise_deadband_count; // see RQ13
        fall_work_next = i_fall_deadband_count;
        ld_next        = 1'b0;
        ld_armed_next  = 1'b0;
      end
      if (i_deadband_load_request) ld_next = 1'b1; // A new request beats a load in the same cycle
    end
  end
  // Timer control: half-bridge edges, or a full-bridge direction change
  always_comb begin
    dir_change = fb & running & rise & (mode[0] != dir_reg);
    r_start    = (hb & running & rise) | (dir_change & mode[0]); // see RQ4, see RQ5, see RQ8
    f_start    = (hb & running & fall) | (dir_change & ~mode[0]); // see RQ9
    r_stop     = ~running | (hb & fall); // see RQ12
    f_stop     = ~running | (hb & rise);
  end
  cwg_db_timer u_rise_timer (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_start (r_start),
    .i_stop  (r_stop),
    .i_tick  (tick),
    .i_limit (rise_work_reg), // see RQ10
    .o_done  (r_done)
  );
  cwg_db_timer u_fall_timer (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_start (f_start),
    .i_stop  (f_stop),
    .i_tick  (tick),
    .i_limit (fall_work_reg), // see RQ10
    .o_done  (f_done)
  );
  // Waveform state for half-bridge, full-bridge, push-pull and steering
  always_comb begin
    a_on_next   = a_on_reg;
    b_on_next   = b_on_reg;
    dir_next    = dir_reg;
    mod_ok_next = mod_ok_reg;
    pp_a_next   = pp_a_reg;
    str_next    = str_reg;
    if (!running) begin
      a_on_next   = 1'b0;
      b_on_next   = 1'b0;
      dir_next    = mode[0];
      mod_ok_next = 1'b1;
      pp_a_next   = 1'b0; // Sequencer restarts so the first pulse lands on A
    end else begin
      if (rise) begin
        a_on_next = (rise_work_reg == 6'h00); // see RQ11
        b_on_next = 1'b0;
        pp_a_next = ~pp_a_reg;
      end else if (fall) begin
        a_on_next = 1'b0;
        b_on_next = (fall_work_reg == 6'h00); // see RQ11
      end
      if (hb & r_done) a_on_next = 1'b1; // see RQ8
      if (hb & f_done) b_on_next = 1'b1; // see RQ9
      if (dir_change) begin
        dir_next    = mode[0]; // see RQ7
        mod_ok_next = mode[0] ? (rise_work_reg == 6'h00) : (fall_work_reg == 6'h00);
      end else if (fb & (r_done | f_done)) begin
        mod_ok_next = 1'b1; // see RQ7
      end
    end
    if ((mode != cwg_pkg::MODE_STEER_SYNC) | rise) str_next = i_steer_enable;
  end
  // Output levels; polarity applies only to modulated signals and to the inactive level while idle
  always_comb begin
    act = 4'h0;
    case (mode)
      cwg_pkg::MODE_HALF:      act = {~b_on_reg, a_on_reg, b_on_reg, a_on_reg};
      cwg_pkg::MODE_FB_FWD,
      cwg_pkg::MODE_FB_REV:    act = {~dir_reg & mod_ok_reg & d_sync_reg, dir_reg,
                                      dir_reg & mod_ok_reg & d_sync_reg, ~dir_reg};
      cwg_pkg::MODE_PUSH_PULL: act = {d_sync_reg & ~pp_a_reg, d_sync_reg & pp_a_reg,
                                      d_sync_reg & ~pp_a_reg, d_sync_reg & pp_a_reg};
      cwg_pkg::MODE_STEER_ASYNC,
      cwg_pkg::MODE_STEER_SYNC: act = {4{d_sync_reg}};
      default:                 act = 4'h0;
    endcase
    ovr = {i_override_level_bd == `CWG_OVR_HIGH, i_override_level_ac == `CWG_OVR_HIGH,
           i_override_level_bd == `CWG_OVR_HIGH, i_override_level_ac == `CWG_OVR_HIGH}; // see RQ20
    for (int i = 0; i < 4; i++) begin
      if (state_reg == cwg_pkg::ST_IDLE) begin
        out_next[i] = ~i_output_polarity[i];
      end else if (steer & ~str_reg[i]) begin
        out_next[i] = i_steer_level[i]; // see RQ3
      end else if (~running | sd_any | sd_reg) begin
        out_next[i] = ovr[i]; // see RQ3, see RQ17
      end else begin
        out_next[i] = act[i] ^ ~i_output_polarity[i]; // see RQ2
      end
    end
  end

  // State registers
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg               <= cwg_pkg::ST_IDLE;
      div_reg                 <= 8'h00;
      sd_reg                  <= 1'b0;
      rise_work_reg           <= `CWG_DB_RESET;
      fall_work_reg           <= `CWG_DB_RESET;
      ld_reg                  <= 1'b0;
      ld_armed_reg            <= 1'b0;
      a_on_reg                <= 1'b0;
      b_on_reg                <= 1'b0;
      dir_reg                 <= 1'b0;
      mod_ok_reg              <= 1'b1;
      pp_a_reg                <= 1'b0;
      str_reg                 <= 4'h0;
      {o_out_d, o_out_c, o_out_b, o_out_a} <= 4'h0;
      o_shutdown              <= 1'b0;
      o_shutdown_irq_flag     <= 1'b0;
      o_deadband_load_pending <= 1'b0;
    end else begin
      state_reg               <= state_next;
      div_reg                 <= div_next;
      sd_reg                  <= sd_next;
      rise_work_reg           <= rise_work_next;
      fall_work_reg           <= fall_work_next;
      ld_reg                  <= ld_next;
      ld_armed_reg            <= ld_armed_next;
      a_on_reg                <= a_on_next;
      b_on_reg                <= b_on_next;
      dir_reg                 <= dir_next;
      mod_ok_reg              <= mod_ok_next;
      pp_a_reg                <= pp_a_next;
      str_reg                 <= str_next;
      {o_out_d, o_out_c, o_out_b, o_out_a} <= out_next;
      o_shutdown              <= sd_next;
      o_shutdown_irq_flag     <= irq_next;
      o_deadband_load_pending <= ld_next;
    end
  end
endmodule : cwg_core

/* cwg_cfg.svh */
`ifndef CWG_CFG_SVH
`define CWG_CFG_SVH

// Data input selector code that maps to no source
`define CWG_ISM_RESERVED  4'hF
// Reset value of both dead-band working copies
`define CWG_DB_RESET      6'h00
// Generator clock divider: a tick every (LAST + 1) i_mclk cycles
`define CWG_GEN_DIV_LAST  8'h00
// Override field code that drives a high level; every other code drives low
`define CWG_OVR_HIGH      2'h3
// Shutdown source positions in the enable vector
`define CWG_SD_PIN        0
`define CWG_SD_TMR_LO     1
`define CWG_SD_TMR_HI     3
`define CWG_SD_CMP_LO     4
`define CWG_SD_CMP_HI     5
`define CWG_SD_CLC        6

`endif

/* cwg_pkg.sv */
package cwg_pkg;

  // Output mode field
  typedef enum logic [2:0] {
    MODE_STEER_ASYNC = 3'h0,
    MODE_STEER_SYNC  = 3'h1,
    MODE_FB_FWD      = 3'h2,
    MODE_FB_REV      = 3'h3,
    MODE_HALF        = 3'h4,
    MODE_PUSH_PULL   = 3'h5,
    MODE_RSVD6       = 3'h6,
    MODE_RSVD7       = 3'h7
  } mode_e;

  // Run control, one-hot
  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_RUN    = 4'h2,
    ST_SHUT   = 4'h4,
    ST_RESUME = 4'h8
  } run_state_e;

endpackage : cwg_pkg

/* cwg_core_assertions.sv */
`timescale 1ns/10ps
module cwg_core_chk (
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  input wire logic       i_enable,
  input wire logic [2:0] i_mode,
  input wire logic [3:0] i_output_polarity,
  input wire logic [1:0] i_override_level_bd,
  input wire logic [1:0] i_override_level_ac,
  input wire logic [6:0] i_shutdown_source_enable,
  input wire logic       i_sd_pin_n,
  input wire logic [2:0] i_sd_tmr,
  input wire logic [1:0] i_sd_cmp_n,
  input wire logic       i_sd_clc_n,
  input wire logic       i_auto_restart,
  input wire logic       i_shutdown_set,
  input wire logic       i_shutdown_clear,
  input wire logic       i_deadband_load_request,
  input wire logic       o_out_a,
  input wire logic       o_out_b,
  input wire logic       o_out_c,
  input wire logic       o_out_d,
  input wire logic       o_shutdown,
  input wire logic       o_shutdown_irq_flag,
  input wire logic       o_deadband_load_pending
);
  logic       sd_act;
  logic [3:0] outs;
  // Raw fault level; the design adds its synchroniser delay on top
  assign sd_act = |(i_shutdown_source_enable & {~i_sd_clc_n, ~i_sd_cmp_n, i_sd_tmr, ~i_sd_pin_n});
  assign outs = {o_out_d, o_out_c, o_out_b, o_out_a};
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  property p_irq_rise; $rose(o_shutdown) |-> o_shutdown_irq_flag; endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("flag missing at shutdown entry");
  property p_irq_only; o_shutdown_irq_flag |-> o_shutdown && !$past(o_shutdown); endproperty
  a_irq_only: assert property (p_irq_only) else $error("flag without shutdown entry");
  property p_entry; sd_act [*4] ##0 i_enable |-> o_shutdown; endproperty
  a_entry: assert property (p_entry) else $error("fault did not force shutdown");
  property p_no_clr; $fell(o_shutdown) |-> !(sd_act && $past(sd_act) && $past(sd_act, 2) && $past(sd_act, 4)); endproperty
  a_no_clr: assert property (p_no_clr) else $error("shutdown cleared under live fault");
  property p_sw_set; i_shutdown_set |-> ##[1:3] o_shutdown; endproperty
  a_sw_set: assert property (p_sw_set) else $error("software set ignored");
  property p_persist;
    o_shutdown && !i_auto_restart && !$past(i_auto_restart) && !i_shutdown_clear && !$past(i_shutdown_clear)
      |=> o_shutdown;
  endproperty
  a_persist: assert property (p_persist) else $error("shutdown dropped without clear");
  property p_ovr;
    o_shutdown [*3] ##0 (i_mode inside {[3'h2:3'h5]} && $stable(i_override_level_ac) && $stable(i_override_level_bd))
      |-> outs == {&i_override_level_bd, &i_override_level_ac, &i_override_level_bd, &i_override_level_ac};
  endproperty
  a_ovr: assert property (p_ovr) else $error("override levels wrong");
  property p_hb_safe;
    i_mode == 3'h4 && $past(i_mode) == 3'h4 && i_output_polarity == 4'hF && $stable(i_output_polarity)
      && !o_shutdown && !(&{i_override_level_ac, i_override_level_bd}) |-> !(o_out_a && o_out_b);
  endproperty
  a_hb_safe: assert property (p_hb_safe) else $error("half-bridge outputs overlap");
  property p_ld_set; i_enable && $past(i_enable) && i_deadband_load_request |=> o_deadband_load_pending; endproperty
  a_ld_set: assert property (p_ld_set) else $error("load request not held");
  property p_ld_clr; !i_enable [*2] |-> !o_deadband_load_pending; endproperty
  a_ld_clr: assert property (p_ld_clr) else $error("load request kept while disabled");
endmodule : cwg_core_chk

/* cwg_src_model.sv */
`timescale 1ns/10ps
module cwg_src_model (
  input  wire logic [3:0] i_sel,
  input  wire logic       i_mclk,
  input  wire logic       i_data,
  input  wire logic [6:0] i_fault,
  output logic            o_pin,
  output logic [3:0]      o_ccp,
  output logic [1:0]      o_pwm,
  output logic            o_nco,
  output logic [1:0]      o_cmp,
  output logic            o_dsm,
  output logic [3:0]      o_clc,
  output logic            o_sd_pin_n,
  output logic [2:0]      o_sd_tmr,
  output logic [1:0]      o_sd_cmp_n,
  output logic            o_sd_clc_n
);
  logic        tgl = 1'b0;
  logic [14:0] v;
  // Unselected sources toggle every cycle so a wrong pick shows up
  always @(negedge i_mclk) tgl <= ~tgl;
  always_comb begin
    v = {15{tgl}};
    if (i_sel != 4'hF) v[i_sel] = i_data;
  end
  assign {o_clc, o_dsm, o_cmp, o_nco, o_pwm, o_ccp, o_pin} = v;
  // Pin, comparator and logic-cell faults pull low, timer faults go high
  assign {o_sd_clc_n, o_sd_cmp_n, o_sd_tmr, o_sd_pin_n} = {~i_fault[6], ~i_fault[5:4], i_fault[3:1], ~i_fault[0]};
endmodule : cwg_src_model

/* tb.sv */
`timescale 1ns/10ps
module tb;
  logic       mclk = 1'b0;
  logic       rst_n, en, sd_set, sd_clr, auto_rs, rwr, fwr, ldreq, data, seen;
  logic       oa, ob, oc, od, sd, irq, ldp, s_pin, s_nco, s_dsm, f_pin_n, f_clc_n;
  logic [2:0] mode, f_tmr;
  logic [3:0] input_source_select, pol, s_ccp, s_clc, outs;
  logic [1:0] ovr_bd, ovr_ac, s_pwm, s_cmp, f_cmp_n;
  logic [6:0] sd_en, fault;
  logic [5:0] rcnt, fcnt;
  logic [5:0] tbl [3] = '{6'h00, 6'h03, 6'h3F};
  int         bad_count = 0, total_checks = 0, cycles = 0, irq_n = 0, dr0, df0, n, m;

  cwg_core u_dut (
    .i_mclk(mclk), .i_rst_n(rst_n), .i_enable(en), .i_mode(mode), .i_input_source_select(input_source_select),
    .i_input_pin_route(s_pin), .i_src_ccp(s_ccp), .i_src_pwm(s_pwm), .i_src_nco(s_nco), .i_src_cmp(s_cmp),
    .i_src_dsm(s_dsm), .i_src_clc(s_clc), .i_output_polarity(pol), .i_steer_enable(4'hF),
    .i_steer_level(4'h0), .i_override_level_bd(ovr_bd), .i_override_level_ac(ovr_ac),
    .i_shutdown_source_enable(sd_en), .i_sd_pin_n(f_pin_n), .i_sd_tmr(f_tmr), .i_sd_cmp_n(f_cmp_n),
    .i_sd_clc_n(f_clc_n), .i_auto_restart(auto_rs), .i_shutdown_set(sd_set), .i_shutdown_clear(sd_clr),
    .i_rise_deadband_count(rcnt), .i_rise_deadband_wr(rwr), .i_fall_deadband_count(fcnt),
    .i_fall_deadband_wr(fwr), .i_deadband_load_request(ldreq), .o_out_a(oa), .o_out_b(ob), .o_out_c(oc),
    .o_out_d(od), .o_shutdown(sd), .o_shutdown_irq_flag(irq), .o_deadband_load_pending(ldp));
  cwg_src_model u_src (
    .i_sel(input_source_select), .i_mclk(mclk), .i_data(data), .i_fault(fault), .o_pin(s_pin), .o_ccp(s_ccp),
    .o_pwm(s_pwm), .o_nco(s_nco), .o_cmp(s_cmp), .o_dsm(s_dsm), .o_clc(s_clc), .o_sd_pin_n(f_pin_n),
    .o_sd_tmr(f_tmr), .o_sd_cmp_n(f_cmp_n), .o_sd_clc_n(f_clc_n));
  assign outs = {od, oc, ob, oa};

  always #10 mclk = ~mclk;

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // Cycle ceiling for a hung design, and shutdown flag pulse count
  always @(negedge mclk) begin
    cycles++;
    if (irq === 1'b1) irq_n++;
    if (cycles == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk);
  endtask : cyc
  // Set the data level and count cycles until the chosen output reads high
  task automatic meas(input logic lvl, input int idx, output int c);
    data = lvl;
    c = 0;
    while (outs[idx] !== 1'b1 && c < 200) begin
      cyc(1);
      c++;
    end
    cyc(80);
  endtask : meas
  // One-cycle software set or clear of the shutdown bit
  task automatic kick(input logic s);
    sd_set = s;
    sd_clr = ~s;
    cyc(1);
    sd_set = 1'b0;
    sd_clr = 1'b0;
  endtask : kick

  initial begin
    {en, mode, input_source_select, ovr_bd, ovr_ac, sd_en, auto_rs, sd_set, sd_clr, rcnt, rwr, fcnt, fwr, ldreq, data, fault} = '0;
    pol = 4'h5;
    rst_n = 1'b0;
    cyc(8);
    rst_n = 1'b1;
    en = 1'b1;
    // Steering mode passes each selected source straight through
    for (int s = 0; s < 16; s++) begin
      input_source_select = s[3:0];
      data = 1'b1;
      cyc(6);
      check("steer_hi", {4'h0, (s == 15) ? ~pol : pol}, {4'h0, outs});
      data = 1'b0;
      cyc(6);
      check("steer_lo", {4'h0, ~pol}, {4'h0, outs});
    end
    $display("test steering done");
    // Half-bridge dead band: extra delay over a zero count equals the count
    for (int k = 0; k < 3; k++) begin
      en = 1'b0;
      mode = 3'h4;
      pol = 4'hF;
      input_source_select = 4'h0;
      {rcnt, fcnt, rwr, fwr} = {tbl[k], tbl[k], 2'h3};
      cyc(1);
      {rwr, fwr} = 2'h0;
      en = 1'b1;
      meas(1'b1, 0, n);
      meas(1'b0, 1, m);
      meas(1'b1, 0, n);
      check("hb_rise", 8'h01, {6'h0, ob, oa});
      meas(1'b0, 1, m);
      if (k == 0) {dr0, df0} = {n, m};
      check("rise_db", {2'h0, tbl[k]}, 8'(n - dr0));
      check("fall_db", {2'h0, tbl[k]}, 8'(m - df0));
    end
    // A pulse shorter than the dead band never reaches out_a
    seen = 1'b0;
    data = 1'b1;
    for (int i = 0; i < 100; i++) begin
      if (i == 10) data = 1'b0;
      cyc(1);
      seen = seen | oa;
    end
    check("short_pulse", 8'h00, {7'h0, seen});
    $display("test dead band done");
    // Enabled reload waits for a falling then a rising data edge
    {rcnt, fcnt, ldreq} = {6'h02, 6'h02, 1'b1};
    cyc(1);
    ldreq = 1'b0;
    cyc(2);
    check("ld_pend", 8'h01, {7'h0, ldp});
    meas(1'b1, 0, n);
    check("old_db", 8'h3F, 8'(n - dr0));
    check("ld_wait", 8'h01, {7'h0, ldp});
    meas(1'b0, 1, m);
    meas(1'b1, 0, n);
    check("ld_done", 8'h00, {7'h0, ldp});
    meas(1'b0, 1, m);
    meas(1'b1, 0, n);
    check("new_db", 8'h02, 8'(n - dr0));
    // Full-bridge reversal: A and C swap at the rising edge, B waits out the rise count
    data = 1'b0;
    mode = 3'h3;
    cyc(8);
    meas(1'b1, 1, m);
    check("fb_swap", 8'h06, {4'h0, outs});
    check("fb_db", 8'h02, 8'(m - dr0));
    $display("test reload done");
    // Each fault source, masked then enabled, with active-low outputs
    data = 1'b0;
    mode = 3'h4;
    pol = 4'h0;
    ovr_ac = 2'h3;
    cyc(80);
    for (int y = 0; y < 7; y++) begin
      fault = 7'h01 << y;
      sd_en = ~fault;
      cyc(10);
      check("sd_masked", 8'h00, {7'h0, sd});
      sd_en = 7'h7F;
      cyc(6);
      check("sd_on", 8'h01, {7'h0, sd});
      check("ovr", 8'h05, {4'h0, outs});
      kick(1'b0);
      cyc(8);
      check("sd_held", 8'h01, {7'h0, sd});
      fault = 7'h00;
      cyc(8);
      check("sd_stay", 8'h01, {7'h0, sd});
      kick(1'b0);
      cyc(8);
      check("sd_off", 8'h00, {7'h0, sd});
      check("resume_wait", 8'h05, {4'h0, outs});
      meas(1'b1, 1, n);
      check("resume_run", 8'h02, {6'h0, ob, oa});
      meas(1'b0, 0, n);
    end
    kick(1'b1);
    cyc(20);
    check("sw_hold", 8'h01, {7'h0, sd});
    kick(1'b0);
    cyc(4);
    check("sw_clr", 8'h00, {7'h0, sd});
    auto_rs = 1'b1;
    kick(1'b1);
    cyc(8);
    check("auto_clr", 8'h00, {7'h0, sd});
    check("auto_wait", 8'h05, {4'h0, outs});
    meas(1'b1, 1, n);
    check("auto_run", 8'h02, {6'h0, ob, oa});
    meas(1'b0, 0, n);
    fault = 7'h04;
    cyc(30);
    check("lvl_hold", 8'h01, {7'h0, sd});
    sd_en = 7'h00;
    cyc(8);
    check("en_clr", 8'h00, {7'h0, sd});
    check("irq_cnt", 8'h0A, 8'(irq_n));
    $display("test shutdown done");
    print_verdict();
  end
endmodule : tb

bind cwg_core cwg_core_chk u_chk (
  .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_enable(i_enable), .i_mode(i_mode),
  .i_output_polarity(i_output_polarity), .i_override_level_bd(i_override_level_bd),
  .i_override_level_ac(i_override_level_ac), .i_shutdown_source_enable(i_shutdown_source_enable),
  .i_sd_pin_n(i_sd_pin_n), .i_sd_tmr(i_sd_tmr), .i_sd_cmp_n(i_sd_cmp_n), .i_sd_clc_n(i_sd_clc_n),
  .i_auto_restart(i_auto_restart), .i_shutdown_set(i_shutdown_set), .i_shutdown_clear(i_shutdown_clear),
  .i_deadband_load_request(i_deadband_load_request), .o_out_a(o_out_a), .o_out_b(o_out_b),
  .o_out_c(o_out_c), .o_out_d(o_out_d), .o_shutdown(o_shutdown), .o_shutdown_irq_flag(o_shutdown_irq_flag),
  .o_deadband_load_pending(o_deadband_load_pending));
